// ===== rtl/iqm_pkg.sv
// Purpose: shared constants, types and helpers of the interpolating quadrature modulator
// Assumes: pclk is the converter update clock
// Notes:   register indices are word indices, byte address is four times the index
package iqm_pkg;

	localparam int unsigned DW = 16;

	// register indices
	localparam logic [9:0] CTL0_IDX = 10'h000;
	localparam logic [9:0] CTL1_IDX = 10'h001;
	localparam logic [9:0] STAT_IDX = 10'h002;

	// control 0 fields
	localparam int unsigned C0_SOFT_RST = 5;
	localparam int unsigned C0_FILT_PD  = 4;
	localparam int unsigned C0_IPD      = 3;
	localparam int unsigned C0_QPD      = 2;

	// control 1 fields
	localparam int unsigned C1_RATE_LO = 6;
	localparam int unsigned C1_HP      = 5;
	localparam int unsigned C1_MOD_LO  = 3;
	localparam int unsigned C1_REAL    = 2;
	localparam int unsigned C1_SIGN    = 1;

	// status fields
	localparam int unsigned ST_FULLPD = 0;
	localparam int unsigned ST_UNDER  = 1;
	localparam int unsigned ST_PH_LO  = 2;

	localparam logic [7:0] CTL0_RST = 8'h00;
	localparam logic [7:0] CTL1_RST = 8'hd4;

	// interpolation rate codes
	localparam logic [1:0] RATE_1X = 2'h0;
	localparam logic [1:0] RATE_2X = 2'h1;
	localparam logic [1:0] RATE_4X = 2'h2;
	localparam logic [1:0] RATE_8X = 2'h3;

	// modulation frequency codes, both upper codes mean quarter rate
	localparam logic [1:0] MOD_OFF  = 2'h0;
	localparam logic [1:0] MOD_HALF = 2'h1;

	// half-band odd-phase taps: (-1, 9, 9, -1) / 16
	localparam int HB_INNER = 9;
	localparam int HB_SHIFT = 4;

	// reset pulse timing
	localparam int unsigned CLK_MHZ      = 200;
	localparam int unsigned RST_PULSE_NS = 10;
	localparam int unsigned RST_CYCLES_I = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam int unsigned RST_CYCLES   = (RST_CYCLES_I < 1) ? 1 : RST_CYCLES_I;
	localparam int unsigned RST_CNT_W    = 2;

	typedef enum logic {IQM_RUN, IQM_SRST} iqm_state_t;

	// clamp a wide signed value into one converter word
	function automatic logic signed [DW-1:0] sat16(input logic signed [21:0] v);
		if (v > 22'sd32767) begin
			return 16'sh7fff;
		end else if (v < -22'sd32768) begin
			return 16'sh8000;
		end
		return v[DW-1:0];
	endfunction

endpackage

// ===== rtl/iqm_halfband.sv
// Purpose: one dual-channel half-band 2x interpolation stage
// Assumes: out_stb runs at twice the rate of in_stb and coincides with every in_stb
// Notes:   even outputs are the centre tap, odd outputs the four-tap odd phase
`timescale 1ns/100ps
module iqm_halfband (
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// control
	input  wire logic                     clr,
	input  wire logic                     in_stb,
	input  wire logic                     out_stb,
	// data
	input  wire logic signed [15:0]       din_i,
	input  wire logic signed [15:0]       din_q,
	output logic signed [15:0]            dout_i,
	output logic signed [15:0]            dout_q
);

	logic signed [15:0] ti_q [4];
	logic signed [15:0] ti_d [4];
	logic signed [15:0] tq_q [4];
	logic signed [15:0] tq_d [4];
	logic signed [15:0] oi_q;
	logic signed [15:0] oi_d;
	logic signed [15:0] oq_q;
	logic signed [15:0] oq_d;

	// odd phase between taps 1 and 2
	function automatic logic signed [15:0] mid(input logic signed [15:0] a, input logic signed [15:0] b,
		input logic signed [15:0] c, input logic signed [15:0] d);
		logic signed [21:0] s;
		s = 22'(iqm_pkg::HB_INNER) * (22'(b) + 22'(c)) - (22'(a) + 22'(d)); // see RL26
		return iqm_pkg::sat16(s >>> iqm_pkg::HB_SHIFT);
	endfunction

	always_comb begin
		ti_d = ti_q;
		tq_d = tq_q;
		oi_d = oi_q;
		oq_d = oq_q;
		if (clr) begin
			ti_d = '{default: '0};
			tq_d = '{default: '0};
			oi_d = '0;
			oq_d = '0;
		end else begin
			if (out_stb) begin
				oi_d = in_stb ? ti_q[1] : mid(ti_q[0], ti_q[1], ti_q[2], ti_q[3]);
				oq_d = in_stb ? tq_q[1] : mid(tq_q[0], tq_q[1], tq_q[2], tq_q[3]);
			end
			if (in_stb) begin
				ti_d = '{din_i, ti_q[0], ti_q[1], ti_q[2]};
				tq_d = '{din_q, tq_q[0], tq_q[1], tq_q[2]};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ti_q <= '{default: '0};
			tq_q <= '{default: '0};
			oi_q <= '0;
			oq_q <= '0;
		end else begin
			ti_q <= ti_d;
			tq_q <= tq_d;
			oi_q <= oi_d;
			oq_q <= oq_d;
		end
	end

	assign dout_i = oi_q;
	assign dout_q = oq_q;

endmodule

// ===== rtl/iqm_top.sv
// Purpose: dual-channel interpolating quadrature modulator datapath with APB control
// Assumes: pclk is the converter update clock; input samples are requested at the update rate divided by the interpolation factor
// Notes:   three half-band stages, modulator between the second and the third
//
// Summary of operation
// RL1 - three cascaded half-band stages give 1x, 2x, 4x or 8x interpolation
// RL2 - rate field sits in bits 7:6 of control 1
// RL3 - third stage follows the modulator, first two precede it
// RL4 - in 8x the final stage is lowpass or highpass by control 1 bit 5
// RL5 - modulator runs at update rate, or half of it in 8x
// RL6 - modulator emits one sample per input sample; code emits one per mod_stb: 1, 2, 4, 4 per input sample in 1x to 8x
// RL7 - complex mode mixes second-stage output with internal I and Q oscillator
// RL8 - quarter-rate cosine sequence is 1, 0, -1, 0; real or complex allowed
// RL9 - sine sequence is the cosine sequence delayed one modulator cycle
// RL10 - control 1 bit 1 inverts oscillator sign, choosing the rejected image
// RL11 - half-rate mode multiplies both channels by -1, 1
// RL12 - half-rate mode is always real modulation
// RL13 - positive exponent: I = Ic - Qs, Q = Is + Qc
// RL14 - negative exponent: I = Ic + Qs, Q = Qc - Is
// RL15 - real mode: each channel times cosine, no cross terms
// RL16 - reset release puts the oscillator into a fixed initial phase
// RL17 - reset low at least 10 ns returns all control registers to defaults
// RL18 - writing one to control 0 bit 5 resets like the pin
// RL19 - control 0 bits 3 and 2 power down each converter
// RL20 - control 0 bit 4 stops the filters, converters hold their level
// RL21 - both converters down means full power-down including filters
// RL22 - rate codes 00 1x, 01 2x, 10 4x, 11 8x; default 8x
// RL23 - modulation codes 00 off, 01 half, 1x quarter; default quarter
// RL24 - control 1 bit 2 high selects real, low complex; default real
// RL25 - sign zero negative exponent default, one positive exponent
// RL26 - symmetric half-band taps -1, 9, 9, -1 over 16
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
module iqm_top (
	// clock and reset
	input  wire logic               pclk,
	input  wire logic               presetn,
	// apb slave
	input  wire logic [11:0]        paddr,
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [31:0]        pwdata,
	output logic                    pready,
	output logic [31:0]             prdata,
	output logic                    pslverr,
	// sample input
	input  wire logic signed [15:0] in_i,
	input  wire logic signed [15:0] in_q,
	input  wire logic               in_valid,
	output logic                    in_ready,
	// converter outputs
	output logic signed [15:0]      inphase_converter_data,
	output logic signed [15:0]      quadrature_converter_data,
	output logic                    inphase_converter_on,
	output logic                    quadrature_converter_on,
	output logic                    filters_powered
);

	iqm_pkg::iqm_state_t st_q;
	iqm_pkg::iqm_state_t st_d;
	logic [iqm_pkg::RST_CNT_W-1:0] rc_q;
	logic [iqm_pkg::RST_CNT_W-1:0] rc_d;
	logic [7:0]  ctl0_q;
	logic [7:0]  ctl0_d;
	logic [7:0]  ctl1_q;
	logic [7:0]  ctl1_d;
	logic        under_q;
	logic        under_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;

	logic        srst;
	logic        wr;
	logic        hit;
	logic [9:0]  idx;
	logic [1:0]  rate;
	logic [1:0]  modf;
	logic        full_pd;
	logic        run;

	logic [2:0]  cnt_q;
	logic [2:0]  cnt_d;
	logic [1:0]  ph_q;
	logic [1:0]  ph_d;
	logic signed [15:0] x_i_q;
	logic signed [15:0] x_i_d;
	logic signed [15:0] x_q_q;
	logic signed [15:0] x_q_d;
	logic signed [15:0] m_i_q;
	logic signed [15:0] m_i_d;
	logic signed [15:0] m_q_q;
	logic signed [15:0] m_q_d;
	logic signed [15:0] o_i_q;
	logic signed [15:0] o_i_d;
	logic signed [15:0] o_q_q;
	logic signed [15:0] o_q_d;

	logic        in_stb;
	logic        s1_out;
	logic        s2_out;
	logic        mod_stb;
	logic signed [15:0] s1_i;
	logic signed [15:0] s1_q;
	logic signed [15:0] s2_i;
	logic signed [15:0] s2_q;
	logic signed [15:0] s3_i;
	logic signed [15:0] s3_q;
	logic signed [15:0] a_i;
	logic signed [15:0] a_q;
	logic signed [15:0] b_i;
	logic signed [15:0] b_q;
	logic signed [15:0] c_i;
	logic signed [15:0] c_q;
	logic signed [1:0]  lo_c;
	logic signed [1:0]  lo_s;

	// strobe with period 2**lg taken from the tick counter, which advances only while run is high
	function automatic logic tick(input logic [2:0] c, input logic [1:0] lg);
		case (lg)
			2'h0:    return 1'b1;
			2'h1:    return c[0] == 1'b0;
			2'h2:    return c[1:0] == 2'h0;
			default: return c == 3'h0;
		endcase
	endfunction

	// quarter-rate cosine: 1, 0, -1, 0
	function automatic logic signed [1:0] qcos(input logic [1:0] p);
		case (p)
			2'h0:    return 2'sb01;
			2'h2:    return 2'sb11;
			default: return 2'sb00;
		endcase
	endfunction

	// multiply a sample by -1, 0 or +1
	function automatic logic signed [21:0] mul(input logic signed [15:0] x, input logic signed [1:0] m);
		case (m)
			2'sb01:  return 22'(x);
			2'sb11:  return -22'(x);
			default: return 22'sd0;
		endcase
	endfunction

	// ---------------- register file ----------------
	assign srst    = (st_q == iqm_pkg::IQM_SRST);
	assign idx     = paddr[11:2];
	assign hit     = (paddr[1:0] == 2'h0) &&
		(idx == iqm_pkg::CTL0_IDX || idx == iqm_pkg::CTL1_IDX || idx == iqm_pkg::STAT_IDX);
	assign wr      = psel && penable && pwrite && hit;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit;
	assign prdata  = prdata_q;

	assign rate    = ctl1_q[iqm_pkg::C1_RATE_LO +: 2]; // see RL2
	assign modf    = ctl1_q[iqm_pkg::C1_MOD_LO +: 2]; // see RL23
	assign full_pd = ctl0_q[iqm_pkg::C0_IPD] && ctl0_q[iqm_pkg::C0_QPD]; // see RL21
	assign run     = !ctl0_q[iqm_pkg::C0_FILT_PD] && !full_pd && !srst; // see RL20

	always_comb begin
		st_d     = st_q;
		rc_d     = rc_q;
		ctl0_d   = ctl0_q;
		ctl1_d   = ctl1_q;
		under_d  = under_q | (in_stb && !in_valid);
		prdata_d = prdata_q;
		if (srst) begin
			ctl0_d  = iqm_pkg::CTL0_RST; // see RL18
			ctl1_d  = iqm_pkg::CTL1_RST;
			under_d = 1'b0;
			if (rc_q == '0) begin
				st_d = iqm_pkg::IQM_RUN;
			end else begin
				rc_d = rc_q - 1'b1;
			end
		end else if (wr) begin
			if (idx == iqm_pkg::CTL0_IDX) begin
				if (pwdata[iqm_pkg::C0_SOFT_RST]) begin
					st_d = iqm_pkg::IQM_SRST; // see RL18
					rc_d = iqm_pkg::RST_CNT_W'(iqm_pkg::RST_CYCLES - 1);
				end else begin
					ctl0_d = pwdata[7:0] & 8'h1c; // see RL19
				end
			end else if (idx == iqm_pkg::CTL1_IDX) begin
				ctl1_d = pwdata[7:0] & 8'hfe;
			end else if (pwdata[iqm_pkg::ST_UNDER] && !(in_stb && !in_valid)) begin
				// a new underrun in the clearing cycle wins over the clear
				under_d = 1'b0;
			end
		end
		if (psel && !penable && !pwrite) begin
			prdata_d = 32'h0;
			if (idx == iqm_pkg::CTL0_IDX && hit) begin
				prdata_d[7:0] = ctl0_q;
			end else if (idx == iqm_pkg::CTL1_IDX && hit) begin
				prdata_d[7:0] = ctl1_q;
			end else if (hit) begin
				prdata_d[iqm_pkg::ST_FULLPD]     = full_pd;
				prdata_d[iqm_pkg::ST_UNDER]      = under_q;
				prdata_d[iqm_pkg::ST_PH_LO +: 2] = ph_q;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q     <= iqm_pkg::IQM_RUN;
			rc_q     <= '0;
			ctl0_q   <= iqm_pkg::CTL0_RST; // see RL17
			ctl1_q   <= iqm_pkg::CTL1_RST; // see RL22
			under_q  <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			st_q     <= st_d;
			rc_q     <= rc_d;
			ctl0_q   <= ctl0_d;
			ctl1_q   <= ctl1_d;
			under_q  <= under_d;
			prdata_q <= prdata_d;
		end
	end

	// ---------------- rate strobes ----------------
	assign in_stb   = run && tick(cnt_q, rate); // see RL1
	assign in_ready = in_stb;
	assign s1_out   = run && (rate != iqm_pkg::RATE_1X) && tick(cnt_q, 2'(rate - 2'h1));
	assign s2_out   = run && (rate >= iqm_pkg::RATE_4X) && tick(cnt_q, 2'(rate - 2'h2));
	assign mod_stb  = run && tick(cnt_q, (rate == iqm_pkg::RATE_8X) ? 2'h1 : 2'h0); // see RL5

	iqm_halfband u_stage1 (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (srst),
		.in_stb  (in_stb),
		.out_stb (s1_out),
		.din_i   (x_i_q),
		.din_q   (x_q_q),
		.dout_i  (s1_i),
		.dout_q  (s1_q)
	);

	iqm_halfband u_stage2 (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (srst),
		.in_stb  (s1_out && s2_out),
		.out_stb (s2_out),
		.din_i   (s1_i),
		.din_q   (s1_q),
		.dout_i  (s2_i),
		.dout_q  (s2_q)
	);

	// final_halfband_stage follows the modulator
	iqm_halfband final_halfband_stage (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (srst),
		.in_stb  (mod_stb && rate == iqm_pkg::RATE_8X),
		.out_stb (run && rate == iqm_pkg::RATE_8X),
		.din_i   (m_i_q),
		.din_q   (m_q_q),
		.dout_i  (s3_i),
		.dout_q  (s3_q)
	); // see RL3

	// bypass unused stages
	assign a_i = (rate == iqm_pkg::RATE_1X) ? x_i_q : s1_i;
	assign a_q = (rate == iqm_pkg::RATE_1X) ? x_q_q : s1_q;
	assign b_i = (rate >= iqm_pkg::RATE_4X) ? s2_i : a_i;
	assign b_q = (rate >= iqm_pkg::RATE_4X) ? s2_q : a_q;
	assign lo_c = qcos(ph_q); // see RL8
	assign lo_s = qcos(2'(ph_q - 2'h1)); // see RL9

	// ---------------- modulator and outputs ----------------
	always_comb begin
		cnt_d = run ? 3'(cnt_q + 3'h1) : cnt_q;
		ph_d  = ph_q;
		x_i_d = x_i_q;
		x_q_d = x_q_q;
		m_i_d = m_i_q;
		m_q_d = m_q_q;
		if (in_stb) begin
			x_i_d = in_valid ? in_i : 16'sh0000;
			x_q_d = in_valid ? in_q : 16'sh0000;
		end
		if (mod_stb) begin
			ph_d = 2'(ph_q + 2'h1); // see RL6
			if (modf == iqm_pkg::MOD_OFF) begin
				m_i_d = b_i;
				m_q_d = b_q;
			end else if (modf == iqm_pkg::MOD_HALF) begin
				m_i_d = iqm_pkg::sat16(mul(b_i, ph_q[0] ? 2'sb01 : 2'sb11)); // see RL11 RL12
				m_q_d = iqm_pkg::sat16(mul(b_q, ph_q[0] ? 2'sb01 : 2'sb11));
			end else if (ctl1_q[iqm_pkg::C1_REAL]) begin
				m_i_d = iqm_pkg::sat16(mul(b_i, lo_c)); // see RL15 RL24
				m_q_d = iqm_pkg::sat16(mul(b_q, lo_c));
			end else if (ctl1_q[iqm_pkg::C1_SIGN]) begin
				m_i_d = iqm_pkg::sat16(mul(b_i, lo_c) - mul(b_q, lo_s)); // see RL7 RL10 RL13 RL25
				m_q_d = iqm_pkg::sat16(mul(b_i, lo_s) + mul(b_q, lo_c));
			end else begin
				m_i_d = iqm_pkg::sat16(mul(b_i, lo_c) + mul(b_q, lo_s)); // see RL14 RL25
				m_q_d = iqm_pkg::sat16(mul(b_q, lo_c) - mul(b_i, lo_s));
			end
		end
		if (srst) begin
			cnt_d = 3'h0;
			ph_d  = 2'h0; // see RL16
			x_i_d = 16'sh0000;
			x_q_d = 16'sh0000;
			m_i_d = 16'sh0000;
			m_q_d = 16'sh0000;
		end
	end

	// final stage highpass: invert every other output sample of the final stage
	assign c_i = (rate != iqm_pkg::RATE_8X) ? m_i_q :
		(ctl1_q[iqm_pkg::C1_HP] && cnt_q[0]) ? iqm_pkg::sat16(-22'(s3_i)) : s3_i; // see RL4
	assign c_q = (rate != iqm_pkg::RATE_8X) ? m_q_q :
		(ctl1_q[iqm_pkg::C1_HP] && cnt_q[0]) ? iqm_pkg::sat16(-22'(s3_q)) : s3_q;

	always_comb begin
		o_i_d = o_i_q;
		o_q_d = o_q_q;
		if (ctl0_q[iqm_pkg::C0_IPD] || srst) begin
			o_i_d = 16'sh0000; // see RL19
		end else if (run) begin
			o_i_d = c_i;
		end
		if (ctl0_q[iqm_pkg::C0_QPD] || srst) begin
			o_q_d = 16'sh0000;
		end else if (run) begin
			o_q_d = c_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q <= 3'h0;
			ph_q  <= 2'h0; // see RL16
			x_i_q <= 16'sh0000;
			x_q_q <= 16'sh0000;
			m_i_q <= 16'sh0000;
			m_q_q <= 16'sh0000;
			o_i_q <= 16'sh0000;
			o_q_q <= 16'sh0000;
		end else begin
			cnt_q <= cnt_d;
			ph_q  <= ph_d;
			x_i_q <= x_i_d;
			x_q_q <= x_q_d;
			m_i_q <= m_i_d;
			m_q_q <= m_q_d;
			o_i_q <= o_i_d;
			o_q_q <= o_q_d;
		end
	end

	assign inphase_converter_data    = o_i_q;
	assign quadrature_converter_data = o_q_q;
	assign inphase_converter_on      = !ctl0_q[iqm_pkg::C0_IPD];
	assign quadrature_converter_on   = !ctl0_q[iqm_pkg::C0_QPD];
	assign filters_powered           = run; // see RL21

endmodule

// ===== tb/iqm_checker.sv
// Purpose: port-level assertions for iqm_top
// Assumes: zero wait state apb slave with the register map of iqm_pkg
// Notes:   attached by the bind after the module
`timescale 1ns/100ps
module iqm_checker (
	// clock and reset
	input wire logic               pclk,
	input wire logic               presetn,
	// apb
	input wire logic [11:0]        paddr,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [31:0]        pwdata,
	input wire logic               pready,
	input wire logic [31:0]        prdata,
	input wire logic               pslverr,
	// samples and converters
	input wire logic               in_ready,
	input wire logic signed [15:0] inphase_converter_data,
	input wire logic               inphase_converter_on,
	input wire logic               quadrature_converter_on,
	input wire logic               filters_powered
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic acc;
	logic ctl0_wr;
	assign acc     = psel && penable;
	assign ctl0_wr = acc && pwrite && paddr == 12'h000;

	AST_BAD_ADDR: assert property (acc && (paddr[1:0] != 2'h0 || paddr > 12'h008)
		|-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
	AST_GOOD_ADDR: assert property (acc && paddr inside {12'h000, 12'h004, 12'h008}
		|-> pready && !pslverr) else $error("mapped access refused");
	AST_UPPER_ZERO: assert property (acc && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper read bits set");
	AST_I_PD: assert property (ctl0_wr && !pwdata[5] |=> inphase_converter_on == !$past(pwdata[3]))
		else $error("i converter power not from bit 3");
	AST_Q_PD: assert property (ctl0_wr && !pwdata[5] |=> quadrature_converter_on == !$past(pwdata[2]))
		else $error("q converter power not from bit 2");
	AST_FULL_PD: assert property (!inphase_converter_on && !quadrature_converter_on |-> !filters_powered)
		else $error("filters run in full power-down");
	AST_PD_ZERO: assert property (!inphase_converter_on && !$past(inphase_converter_on)
		|-> inphase_converter_data == 16'sh0) else $error("powered-down output not zero");
	AST_NO_TAKE: assert property (!filters_powered |-> !in_ready)
		else $error("sample taken while filters off");
	AST_SOFT_RST: assert property (ctl0_wr && pwdata[5] |=> (!filters_powered && !in_ready
		&& inphase_converter_on && quadrature_converter_on) [*2] ##1 filters_powered)
		else $error("soft reset sequence wrong");
	AST_PHASE_START: assert property (!$past(presetn) |-> in_ready)
		else $error("no sample taken at reset release");
endmodule

bind iqm_top iqm_checker iqm_checker_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata),
	.pslverr(pslverr), .in_ready(in_ready), .inphase_converter_data(inphase_converter_data),
	.inphase_converter_on(inphase_converter_on), .quadrature_converter_on(quadrature_converter_on),
	.filters_powered(filters_powered));

// ===== tb/iqm_dac_model.sv
// Purpose: behavioural pair of converter cores fed by the datapath
// Assumes: codes are two's complement, one update per pclk
// Notes:   level is the code the core steers, zero when powered down
`timescale 1ns/100ps
module iqm_dac_model (
	// clock
	input wire logic               pclk,
	// converter inputs
	input wire logic signed [15:0] inphase_converter_data,
	input wire logic signed [15:0] quadrature_converter_data,
	input wire logic               inphase_converter_on,
	input wire logic               quadrature_converter_on,
	// steered levels
	output logic signed [15:0]     level_i,
	output logic signed [15:0]     level_q
);
	// a core without power steers no current
	always_ff @(posedge pclk) begin
		level_i <= inphase_converter_on ? inphase_converter_data : 16'sh0;
		level_q <= quadrature_converter_on ? quadrature_converter_data : 16'sh0;
	end
endmodule

// ===== tb/tb_top.sv
// Purpose: self-checking bench of iqm_top over apb with constant samples
// Assumes: pclk 200 MHz, sample source always ready unless a test drops it
// Notes:   modulator phase is searched, pipeline latency is not fixed
`timescale 1ns/100ps
module tb_top;
	localparam int SX = 1000;
	localparam int SY = 300;
	logic               pclk;
	logic               presetn;
	logic [11:0]        paddr;
	logic               psel;
	logic               penable;
	logic               pwrite;
	logic [31:0]        pwdata;
	logic               pready;
	logic [31:0]        prdata;
	logic               pslverr;
	logic signed [15:0] in_i;
	logic signed [15:0] in_q;
	logic               in_valid;
	logic               in_ready;
	logic signed [15:0] dat_i;
	logic signed [15:0] dat_q;
	logic               on_i;
	logic               on_q;
	logic               filt_on;
	logic signed [15:0] lvl_i;
	logic signed [15:0] lvl_q;
	int                 fails;
	int                 n_compared;

	iqm_top iqm_top_i (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.in_i(in_i), .in_q(in_q), .in_valid(in_valid), .in_ready(in_ready),
		.inphase_converter_data(dat_i), .quadrature_converter_data(dat_q),
		.inphase_converter_on(on_i), .quadrature_converter_on(on_q), .filters_powered(filt_on));
	iqm_dac_model iqm_dac_model_i (.pclk(pclk), .inphase_converter_data(dat_i),
		.quadrature_converter_data(dat_q), .inphase_converter_on(on_i),
		.quadrature_converter_on(on_q), .level_i(lvl_i), .level_q(lvl_q));

	always #2.5 pclk = ~pclk;

	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			$display("BAD %s expected %h seen %h", nm, e, g);
			fails++;
		end
	endtask

	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		paddr   <= a;
		pwrite  <= w;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		pwdata  <= ~wd;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'b1, d, r, e);
	endtask

	task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m, input logic ee);
		logic [31:0] r;
		logic        er;
		apb(a, 1'b0, 32'h0, r, er);
		chk(nm, e, r & m);
		chk({nm, " error"}, {31'h0, ee}, {31'h0, er});
	endtask

	// k: 0 quarter rate, 1 half rate, 2 no modulation
	function automatic int lo(input int k, input int n);
		case (k)
			0: return (n % 2) ? 0 : ((n % 4) ? -1 : 1);
			1: return (n % 2) ? 1 : -1;
			default: return 1;
		endcase
	endfunction

	// a, b: signs of the cross terms in the i and q outputs
	task automatic mod_chk(input string nm, input logic [7:0] c1, input int k, input int a, input int b);
		logic signed [15:0] oi [8];
		logic signed [15:0] oq [8];
		logic               ok;
		logic               m;
		int                 s;
		wr(12'h004, {24'h0, c1});
		repeat (80) @(posedge pclk);
		for (int n = 0; n < 8; n++) begin
			@(posedge pclk);
			oi[n] = dat_i;
			oq[n] = dat_q;
		end
		ok = 1'b0;
		for (int p = 0; p < 4; p++) begin
			m = 1'b1;
			for (int n = 0; n < 8; n++) begin
				s = (k == 0) ? lo(0, n + p + 3) : 0;
				if (oi[n] !== 16'(SX * lo(k, n + p) + a * SY * s)) m = 1'b0;
				if (oq[n] !== 16'(SY * lo(k, n + p) + b * SX * s)) m = 1'b0;
			end
			if (m) ok = 1'b1;
		end
		chk({nm, " ", $sformatf("%h", c1)}, 32'h1, {31'h0, ok});
	endtask

	logic [7:0]         mc1 [6] = '{8'h14, 8'h1c, 8'h10, 8'h12, 8'h0c, 8'h08};
	int                 mk  [6] = '{0, 0, 0, 0, 1, 1};
	int                 ma  [6] = '{0, 0, 1, -1, 0, 0};
	int                 mb  [6] = '{0, 0, -1, 1, 0, 0};
	int                 cnt;
	logic signed [15:0] held;

	initial begin
		repeat (20000) @(posedge pclk);
		fails++;
		end_of_test();
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		paddr = 12'h0;
		pwrite = 1'b0;
		pwdata = 32'h0;
		in_i = 16'(SX);
		in_q = 16'(SY);
		in_valid = 1'b1;
		fails = 0;
		n_compared = 0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("ctl0 reset", 12'h000, 32'h00, 32'hff, 1'b0);
		rdchk("ctl1 reset", 12'h004, 32'hd4, 32'hff, 1'b0);
		rdchk("unmapped", 12'h00c, 32'h0, 32'hffffffff, 1'b1);
		rdchk("misaligned", 12'h002, 32'h0, 32'hffffffff, 1'b1);
		for (int r = 0; r < 4; r++) begin
			mod_chk("dc path", {2'(r), 6'h04}, 2, 0, 0);
			cnt = 0;
			repeat (64) begin
				@(posedge pclk);
				if (in_ready === 1'b1) cnt++;
			end
			chk("in_ready count", 32'(64 >> r), 32'(cnt));
		end
		mod_chk("final stage highpass", 8'he4, 1, 0, 0);
		for (int i = 0; i < 6; i++) begin
			mod_chk("modulator", mc1[i], mk[i], ma[i], mb[i]);
		end
		wr(12'h000, 32'h08);
		repeat (3) @(posedge pclk);
		chk("i on", 32'h0, {31'h0, on_i});
		chk("q on", 32'h1, {31'h0, on_q});
		chk("i level", 32'h0, 32'(lvl_i));
		wr(12'h000, 32'h0c);
		repeat (3) @(posedge pclk);
		chk("filters full pd", 32'h0, {31'h0, filt_on});
		chk("q level", 32'h0, 32'(lvl_q));
		rdchk("status full pd", 12'h008, 32'h1, 32'h1, 1'b0);
		wr(12'h000, 32'h00);
		repeat (8) @(posedge pclk);
		wr(12'h000, 32'h10);
		repeat (3) @(posedge pclk);
		held = dat_i;
		chk("held level", 32'(SX), 32'((held < 0) ? -held : held));
		repeat (20) @(posedge pclk);
		chk("held output", 32'(held), 32'(dat_i));
		chk("filters pd", 32'h0, {31'h0, filt_on});
		chk("both on", 32'h3, {30'h0, on_i, on_q});
		wr(12'h000, 32'h00);
		wr(12'h004, 32'h0c);
		wr(12'h000, 32'h28);
		repeat (4) @(posedge pclk);
		rdchk("phase after soft reset", 12'h008, 32'h8, 32'hc, 1'b0);
		rdchk("ctl0 soft reset", 12'h000, 32'h00, 32'hff, 1'b0);
		rdchk("ctl1 soft reset", 12'h004, 32'hd4, 32'hff, 1'b0);
		wr(12'h004, 32'h0c);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		rdchk("phase at release", 12'h008, 32'h4, 32'hf, 1'b0);
		rdchk("ctl1 pin reset", 12'h004, 32'hd4, 32'hff, 1'b0);
		end_of_test();
	end
endmodule
